// [rtl/tcc_consts.svh]
// Constants of the timer 2 compare, capture and reload block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Oscillator periods per machine cycle, expressed as last count value
`define TCC_MC_LAST 3'h5
`define TCC_MC_ZERO 3'h0
`define TCC_MC_ONE 3'h1

// Count boundaries
`define TCC_CNT_ZERO 16'h0000
`define TCC_CNT_ONES 16'hffff
`define TCC_CNT_ONE 16'h0001

// Channel layout: channel 0 is the reload/capture register
`define TCC_NUM_CH 4
`define TCC_CH_RELOAD 0

// Level a pulled-up pin rests at, so no false edge follows reset
`define TCC_PIN_IDLE 1'b1

// Synchronised pin layout
`define TCC_NUM_PIN 6
`define TCC_PIN_GATE 0
`define TCC_PIN_TRIG 1
`define TCC_PIN_CAP0 2

// Byte positions inside a 16-bit register
`define TCC_LO_MSB 7
`define TCC_HI_LSB 8
`define TCC_HI_MSB 15

`endif

// [rtl/tcc_pin_sync.sv]
// Pin synchroniser with machine-cycle sampling and edge detection
`timescale 1ns/100ps
`include "tcc_consts.svh"
module tcc_pin_sync (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_pin,
  input wire logic i_sample,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);

  logic meta_q;
  logic sync_q;
  logic samp_q;
  logic prev_q;
  logic rise_q;
  logic fall_q;

  // Two-stage synchroniser; only sync_q reads meta_q
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= `TCC_PIN_IDLE;
      sync_q <= `TCC_PIN_IDLE;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
    end
  end

  // Sample once per machine cycle; an edge needs two samples
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      samp_q <= `TCC_PIN_IDLE;
      prev_q <= `TCC_PIN_IDLE;
    end else if (i_sample) begin
      samp_q <= sync_q;
      prev_q <= samp_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= i_sample && sync_q && !samp_q;
      fall_q <= i_sample && !sync_q && samp_q;
    end
  end

  assign o_level = samp_q;
  assign o_rise = rise_q;
  assign o_fall = fall_q;

endmodule

// [rtl/tcc_pkg.sv]
// Types of the timer 2 compare, capture and reload block
package tcc_pkg;

  typedef enum logic [1:0] {
    TCC_TM_STOP = 2'b00,
    TCC_TM_TIMER = 2'b01,
    TCC_TM_COUNTER = 2'b10,
    TCC_TM_GATED = 2'b11
  } tcc_tmode_type;

  typedef enum logic [1:0] {
    TCC_RL_OFF = 2'b00,
    TCC_RL_OVF = 2'b01,
    TCC_RL_EXT = 2'b10
  } tcc_rmode_type;

  typedef enum logic [1:0] {
    TCC_CH_OFF = 2'b00,
    TCC_CH_COMPARE = 2'b01,
    TCC_CH_CAP_PIN = 2'b10,
    TCC_CH_CAP_WRITE = 2'b11
  } tcc_chfunc_type;

endpackage

// [rtl/tcc_timer2.sv]
// Timer 2 with compare, capture and reload channels
//
// Summary of operation
// - Count wraps all ones to zero, sets flag
// - Timer counts machine cycles, prescale six or twelve
// - Gated timer counts only while gate high
// - Event counter counts sampled falling gate edges
// - Reload mode 1 reloads from reload register
// - Reload mode 2 reloads on trigger fall
// - Trigger fall sets flag only when enabled
// - Compare match produces pin event and pulse
// - Mode 0: match drives high, overflow low
// - Mode 0 ignores software port latch writes
// - Mode 1: shadow latch copied on match
// - All four registers can capture the count
// - Pin mode: channels 1-3 capture rising edge
// - Reload register capture edge is selectable
// - Write mode: low byte write captures next cycle
// - Software-triggered captures raise no request
// - Four compare outputs, four capture inputs
`timescale 1ns/100ps
`include "tcc_consts.svh"
module tcc_timer2 (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [1:0] i_timer_mode,
  input wire logic i_prescale_twelve,
  input wire logic [1:0] i_reload_mode,
  input wire logic i_external_reload_enable,
  input wire logic i_capture_edge_select,
  input wire logic i_compare_mode_one,
  input wire logic [7:0] i_chan_func,
  input wire logic i_gate_count_input,
  input wire logic i_reload_trigger_input,
  input wire logic [3:0] i_capture_pin,
  input wire logic [7:0] i_wdata,
  input wire logic i_count_low_byte_wr,
  input wire logic i_count_high_byte_wr,
  input wire logic [3:0] i_reg_low_wr,
  input wire logic [3:0] i_reg_high_wr,
  input wire logic [3:0] i_port_wr,
  input wire logic [3:0] i_port_wdata,
  input wire logic i_timer_wrap_flag_clr,
  input wire logic i_external_reload_flag_clr,
  output logic [7:0] o_count_low_byte,
  output logic [7:0] o_count_high_byte,
  output logic [15:0] o_reload_capture_value,
  output logic [15:0] o_compare_capture_one,
  output logic [15:0] o_compare_capture_two,
  output logic [15:0] o_compare_capture_three,
  output logic o_timer_wrap_flag,
  output logic o_external_reload_flag,
  output logic [3:0] o_compare_out,
  output logic [3:0] o_match_pulse,
  output logic [3:0] o_capture_pulse
);

  // Channel function of one channel out of the packed field
  function automatic tcc_pkg::tcc_chfunc_type chan_func(input logic [7:0] funcs,
                                                        input int idx);
    logic [1:0] f;
    f = 2'b00;
    case (idx)
      0: f = funcs[1:0];
      1: f = funcs[3:2];
      2: f = funcs[5:4];
      default: f = funcs[7:6];
    endcase
    return tcc_pkg::tcc_chfunc_type'(f);
  endfunction

  tcc_pkg::tcc_tmode_type tmode;
  tcc_pkg::tcc_rmode_type rmode;

  logic [2:0] mc_cnt_q;
  logic [2:0] mc_cnt_d;
  logic mc_tick;
  logic presc_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic count_tick;
  logic wrap;
  logic ext_reload;
  logic count_chg;
  logic cnt_upd_q;
  logic wrapped_q;
  logic wrap_flag_q;
  logic ext_flag_q;
  logic [15:0] reg_q [`TCC_NUM_CH];
  logic [3:0] cmp_out_q;
  logic [3:0] shadow_q;
  logic [3:0] match_now;
  logic [3:0] match_q;
  logic [3:0] hw_cap;
  logic [3:0] hw_cap_q;
  logic [3:0] cap_pend_q;
  logic [`TCC_NUM_PIN-1:0] pin_raw;
  logic [`TCC_NUM_PIN-1:0] pin_level;
  logic [`TCC_NUM_PIN-1:0] pin_rise;
  logic [`TCC_NUM_PIN-1:0] pin_fall;

  assign tmode = tcc_pkg::tcc_tmode_type'(i_timer_mode);
  assign rmode = tcc_pkg::tcc_rmode_type'(i_reload_mode);

  // Machine cycle: six oscillator clocks
  always_comb begin
    if (mc_cnt_q == `TCC_MC_LAST) begin
      mc_cnt_d = `TCC_MC_ZERO;
    end else begin
      mc_cnt_d = mc_cnt_q + `TCC_MC_ONE;
    end
  end

  assign mc_tick = (mc_cnt_q == `TCC_MC_LAST);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mc_cnt_q <= `TCC_MC_ZERO;
    end else begin
      mc_cnt_q <= mc_cnt_d;
    end
  end

  // Divide-by-two stage for the one-twelfth rate
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      presc_q <= 1'b0;
    end else if (mc_tick) begin
      presc_q <= !presc_q;
    end
  end

  // Every external pin passes the synchroniser before edge logic
  assign pin_raw = {i_capture_pin, i_reload_trigger_input, i_gate_count_input};

  generate
    for (genvar p = 0; p < `TCC_NUM_PIN; p++) begin : g_pin
      tcc_pin_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_pin(pin_raw[p]),
        .i_sample(mc_tick),
        .o_level(pin_level[p]),
        .o_rise(pin_rise[p]),
        .o_fall(pin_fall[p])
      );
    end
  endgenerate

  // Count enable per timer function
  always_comb begin
    count_tick = 1'b0;
    unique case (tmode)
      tcc_pkg::TCC_TM_STOP: count_tick = 1'b0;
      tcc_pkg::TCC_TM_TIMER: count_tick = mc_tick && (!i_prescale_twelve || presc_q);
      tcc_pkg::TCC_TM_COUNTER: count_tick = pin_fall[`TCC_PIN_GATE];
      tcc_pkg::TCC_TM_GATED: count_tick = mc_tick && (!i_prescale_twelve || presc_q)
                                          && pin_level[`TCC_PIN_GATE];
    endcase
  end

  assign wrap = count_tick && (count_q == `TCC_CNT_ONES);
  assign ext_reload = pin_fall[`TCC_PIN_TRIG] && (rmode == tcc_pkg::TCC_RL_EXT);

  // Software write wins over reload, reload over increment
  always_comb begin
    count_d = count_q;
    count_chg = 1'b1;
    if (i_count_low_byte_wr || i_count_high_byte_wr) begin
      if (i_count_low_byte_wr) begin
        count_d[`TCC_LO_MSB:0] = i_wdata;
      end
      if (i_count_high_byte_wr) begin
        count_d[`TCC_HI_MSB:`TCC_HI_LSB] = i_wdata;
      end
    end else if (ext_reload) begin
      count_d = reg_q[`TCC_CH_RELOAD];
    end else if (wrap && rmode == tcc_pkg::TCC_RL_OVF) begin
      count_d = reg_q[`TCC_CH_RELOAD];
    end else if (wrap) begin
      count_d = `TCC_CNT_ZERO;
    end else if (count_tick) begin
      count_d = count_q + `TCC_CNT_ONE;
    end else begin
      count_chg = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      count_q <= `TCC_CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // Compare is evaluated in the cycle after the count moves
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_upd_q <= 1'b0;
      wrapped_q <= 1'b0;
    end else begin
      cnt_upd_q <= count_chg;
      wrapped_q <= wrap;
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wrap_flag_q <= 1'b0;
    end else if (wrap) begin
      wrap_flag_q <= 1'b1;
    end else if (i_timer_wrap_flag_clr) begin
      wrap_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_flag_q <= 1'b0;
    end else if (pin_fall[`TCC_PIN_TRIG] && i_external_reload_enable) begin
      ext_flag_q <= 1'b1;
    end else if (i_external_reload_flag_clr) begin
      ext_flag_q <= 1'b0;
    end
  end

  generate
    for (genvar c = 0; c < `TCC_NUM_CH; c++) begin : g_ch
      tcc_pkg::tcc_chfunc_type func;
      logic cap_edge;

      assign func = chan_func(i_chan_func, c);
      assign match_now[c] = cnt_upd_q && (func == tcc_pkg::TCC_CH_COMPARE)
                            && (count_q == reg_q[c]);

      if (c == `TCC_CH_RELOAD) begin : g_sel
        assign cap_edge = i_capture_edge_select ? pin_rise[`TCC_PIN_CAP0 + c]
                                                : pin_fall[`TCC_PIN_CAP0 + c];
      end else begin : g_pos
        assign cap_edge = pin_rise[`TCC_PIN_CAP0 + c];
      end

      assign hw_cap[c] = cap_edge && (func == tcc_pkg::TCC_CH_CAP_PIN);

      // Pending capture one cycle after a low-byte write
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          cap_pend_q[c] <= 1'b0;
        end else begin
          cap_pend_q[c] <= i_reg_low_wr[c] && (func == tcc_pkg::TCC_CH_CAP_WRITE);
        end
      end

      // Register contents: capture beats a plain byte write
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          reg_q[c] <= `TCC_CNT_ZERO;
        end else if (hw_cap[c] || cap_pend_q[c]) begin
          reg_q[c] <= count_q;
        end else begin
          if (i_reg_low_wr[c]) begin
            reg_q[c][`TCC_LO_MSB:0] <= i_wdata;
          end
          if (i_reg_high_wr[c]) begin
            reg_q[c][`TCC_HI_MSB:`TCC_HI_LSB] <= i_wdata;
          end
        end
      end

      // Shadow latch takes every software port write
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          shadow_q[c] <= 1'b0;
        end else if (i_port_wr[c]) begin
          shadow_q[c] <= i_port_wdata[c];
        end
      end

      // Port latch of the compare output pin
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          cmp_out_q[c] <= 1'b0;
        end else if (func != tcc_pkg::TCC_CH_COMPARE) begin
          if (i_port_wr[c]) begin
            cmp_out_q[c] <= i_port_wdata[c];
          end
        end else if (i_compare_mode_one) begin
          if (match_now[c]) begin
            cmp_out_q[c] <= shadow_q[c];
          end
        end else if (match_now[c]) begin
          cmp_out_q[c] <= 1'b1;
        end else if (cnt_upd_q && wrapped_q) begin
          cmp_out_q[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // Event pulses; software captures are not reported
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      match_q <= 4'h0;
      hw_cap_q <= 4'h0;
    end else begin
      match_q <= match_now;
      hw_cap_q <= hw_cap;
    end
  end

  assign o_count_low_byte = count_q[`TCC_LO_MSB:0];
  assign o_count_high_byte = count_q[`TCC_HI_MSB:`TCC_HI_LSB];
  assign o_reload_capture_value = reg_q[0];
  assign o_compare_capture_one = reg_q[1];
  assign o_compare_capture_two = reg_q[2];
  assign o_compare_capture_three = reg_q[3];
  assign o_timer_wrap_flag = wrap_flag_q;
  assign o_external_reload_flag = ext_flag_q;
  assign o_compare_out = cmp_out_q;
  assign o_match_pulse = match_q;
  assign o_capture_pulse = hw_cap_q;

endmodule

// [tb/tcc_pin_model.sv]
// Pulled-up port pins driven with timed pulses
`timescale 1ns/100ps
module tcc_pin_model #(
  parameter int HOLD = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [5:0] i_level,
  input wire logic [5:0] i_pulse,
  output logic [5:0] o_pins
);
  int left [6];
  logic [5:0] act;
  // A pulse inverts the pin for HOLD clocks, over one machine cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int n = 0; n < 6; n++) left[n] <= 0;
    end else begin
      for (int n = 0; n < 6; n++) begin
        if (i_pulse[n]) left[n] <= HOLD;
        else if (left[n] > 0) left[n] <= left[n] - 1;
      end
    end
  end
  always_comb for (int n = 0; n < 6; n++) act[n] = left[n] > 0;
  assign o_pins = i_level ^ act;
endmodule

// [tb/tcc_timer2_bench.sv]
// Self-checking bench for the timer 2 block
`timescale 1ns/100ps
module tcc_timer2_bench;
  typedef struct packed {
    logic [1:0] mode;
    logic twelve;
    logic gate;
    logic [15:0] exp;
  } tcc_row_type;
  logic i_clk_sys, i_nrst, i_prescale_twelve, i_external_reload_enable, i_capture_edge_select;
  logic i_compare_mode_one, i_count_low_byte_wr, i_count_high_byte_wr, i_timer_wrap_flag_clr;
  logic i_external_reload_flag_clr, i_gate_count_input, i_reload_trigger_input;
  logic o_timer_wrap_flag, o_external_reload_flag;
  logic [1:0] i_timer_mode, i_reload_mode;
  logic [7:0] i_chan_func, i_wdata, o_count_low_byte, o_count_high_byte;
  logic [3:0] i_capture_pin, i_reg_low_wr, i_reg_high_wr, i_port_wr, i_port_wdata;
  logic [3:0] o_compare_out, o_match_pulse, o_capture_pulse;
  logic [15:0] o_reload_capture_value, o_compare_capture_one;
  logic [15:0] o_compare_capture_two, o_compare_capture_three;
  logic [5:0] lvl, pls, pins;
  int errors, n_checks;
  tcc_row_type rows [5];
  tcc_timer2 tcc_timer2_i (.*);
  tcc_pin_model #(.HOLD(8)) tcc_pin_model_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_level(lvl), .i_pulse(pls), .o_pins(pins));
  assign i_gate_count_input = pins[0];
  assign i_reload_trigger_input = pins[1];
  assign i_capture_pin = pins[5:2];
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // Strobes are {reg high[3:0], reg low[3:0], count high, count low}
  task automatic put(input logic [7:0] d, input logic [9:0] s);
    i_wdata = d;
    {i_reg_high_wr, i_reg_low_wr, i_count_high_byte_wr, i_count_low_byte_wr} = s;
    step(1);
    {i_reg_high_wr, i_reg_low_wr, i_count_high_byte_wr, i_count_low_byte_wr} = 10'h000;
    step(1);
  endtask
  task automatic pulse(input logic [5:0] p);
    pls = p;
    step(1);
    pls = 6'h00;
  endtask
  task automatic wait_match;
    for (int k = 0; k < 80; k++) begin
      step(1);
      if (o_match_pulse[1] === 1'b1) return;
    end
    errors++;
    $display("MISMATCH at %0t: no match pulse", $time);
    results;
  endtask
  function automatic logic [15:0] cnt();
    return {o_count_high_byte, o_count_low_byte};
  endfunction
  initial begin
    {i_prescale_twelve, i_external_reload_enable, i_capture_edge_select, i_compare_mode_one} = 4'h0;
    {i_count_low_byte_wr, i_count_high_byte_wr, i_timer_wrap_flag_clr} = 3'h0;
    {i_external_reload_flag_clr, i_timer_mode, i_reload_mode, i_chan_func, i_wdata} = 21'h0;
    {i_reg_low_wr, i_reg_high_wr, i_port_wr, i_port_wdata} = 16'h0000;
    lvl = 6'h3f;
    pls = 6'h00;
    errors = 0;
    n_checks = 0;
    rows = '{'{2'h1, 1'b0, 1'b1, 16'h000a}, '{2'h1, 1'b1, 1'b1, 16'h0005},
      '{2'h3, 1'b0, 1'b1, 16'h000a}, '{2'h3, 1'b0, 1'b0, 16'h0000},
      '{2'h0, 1'b0, 1'b1, 16'h0000}};
    i_nrst = 1'b0;
    step(2);
    i_nrst = 1'b1;
    chk(cnt(), 16'h0000);
    chk({o_timer_wrap_flag, o_external_reload_flag, o_compare_out, o_match_pulse}, 16'h0000);
    $display("Test reset done");
    foreach (rows[r]) begin
      i_timer_mode = rows[r].mode;
      i_prescale_twelve = rows[r].twelve;
      lvl[0] = rows[r].gate;
      step(12);
      put(8'h00, 10'h003);
      step(59);
      chk(cnt(), rows[r].exp);
      $display("Test rate row %0d done", r);
    end
    i_timer_mode = 2'h2;
    step(12);
    put(8'h00, 10'h003);
    repeat (3) begin
      pulse(6'h01);
      step(20);
    end
    chk(cnt(), 16'h0003);
    $display("Test event count done");
    put(8'h34, 10'h004);
    put(8'h12, 10'h040);
    i_timer_mode = 2'h1;
    i_reload_mode = 2'h1;
    put(8'hff, 10'h003);
    step(10);
    chk(cnt(), 16'h1235);
    chk(o_timer_wrap_flag, 16'h0001);
    i_timer_wrap_flag_clr = 1'b1;
    step(1);
    i_timer_wrap_flag_clr = 1'b0;
    i_reload_mode = 2'h0;
    put(8'hff, 10'h003);
    step(4);
    chk(cnt(), 16'h0000);
    chk(o_timer_wrap_flag, 16'h0001);
    $display("Test wrap done");
    i_timer_mode = 2'h0;
    i_reload_mode = 2'h2;
    for (int e = 0; e < 2; e++) begin
      i_external_reload_enable = e[0];
      put(8'h00, 10'h003);
      pulse(6'h02);
      step(30);
      chk(cnt(), 16'h1234);
      chk(o_external_reload_flag, e[15:0]);
    end
    $display("Test trigger done");
    i_reload_mode = 2'h0;
    i_chan_func = 8'h04;
    put(8'h05, 10'h008);
    put(8'h00, 10'h080);
    i_port_wr = 4'h2;
    i_port_wdata = 4'hf;
    step(1);
    i_port_wr = 4'h0;
    step(2);
    chk(o_compare_out[1], 16'h0000);
    i_timer_mode = 2'h1;
    put(8'h00, 10'h003);
    wait_match;
    chk(o_compare_out[1], 16'h0001);
    chk(cnt(), 16'h0005);
    put(8'hff, 10'h003);
    step(10);
    chk(o_compare_out[1], 16'h0000);
    i_timer_mode = 2'h0;
    i_compare_mode_one = 1'b1;
    put(8'h00, 10'h003);
    i_port_wr = 4'h2;
    step(1);
    i_port_wr = 4'h0;
    step(3);
    chk(o_compare_out[1], 16'h0000);
    i_timer_mode = 2'h1;
    wait_match;
    step(1);
    chk(o_compare_out[1], 16'h0001);
    $display("Test compare done");
    i_timer_mode = 2'h0;
    i_chan_func = 8'h22;
    put(8'hbc, 10'h001);
    put(8'h0a, 10'h002);
    pulse(6'h14);
    step(40);
    chk(o_compare_capture_two, 16'h0abc);
    chk(o_reload_capture_value, 16'h0abc);
    i_chan_func = 8'hc0;
    put(8'h55, 10'h020);
    step(2);
    chk(o_compare_capture_three, 16'h0abc);
    chk(o_capture_pulse, 16'h0000);
    $display("Test capture done");
    i_nrst = 1'b0;
    step(1);
    chk(o_compare_capture_three, 16'h0000);
    chk(cnt(), 16'h0000);
    i_nrst = 1'b1;
    step(2);
    chk(cnt(), 16'h0000);
    chk({o_timer_wrap_flag, o_external_reload_flag, o_compare_out, o_capture_pulse}, 16'h0000);
    chk(o_reload_capture_value, 16'h0000);
    $display("Test mid reset done");
    results;
  end
endmodule

// [tb/tcc_timer2_monitor.sv]
// Port checker for the timer 2 block
`timescale 1ns/100ps
module tcc_timer2_monitor (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [1:0] i_reload_mode,
  input wire logic i_external_reload_enable,
  input wire logic i_compare_mode_one,
  input wire logic [7:0] i_chan_func,
  input wire logic i_count_low_byte_wr,
  input wire logic i_count_high_byte_wr,
  input wire logic [3:0] i_reg_low_wr,
  input wire logic [7:0] o_count_low_byte,
  input wire logic [7:0] o_count_high_byte,
  input wire logic [15:0] o_reload_capture_value,
  input wire logic [15:0] o_compare_capture_one,
  input wire logic [15:0] o_compare_capture_two,
  input wire logic [15:0] o_compare_capture_three,
  input wire logic o_timer_wrap_flag,
  input wire logic o_external_reload_flag,
  input wire logic [3:0] o_compare_out,
  input wire logic [3:0] o_match_pulse,
  input wire logic [3:0] o_capture_pulse
);
  logic [15:0] cnt;
  logic wr;
  assign cnt = {o_count_high_byte, o_count_low_byte};
  assign wr = i_count_low_byte_wr | i_count_high_byte_wr;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  wrap_sets_flag_a:
  assert property ($past(cnt) == 16'hffff && cnt == 16'h0000 && !$past(wr) &&
    $past(i_reload_mode) == 2'h0 |-> o_timer_wrap_flag) else $error("wrap left flag clear");
  count_step_a:
  assert property (cnt != $past(cnt) && !$past(wr) && $past(i_reload_mode) == 2'h0
    |-> cnt == $past(cnt) + 16'h0001) else $error("count moved by other than one");
  ovf_reload_a:
  assert property ($past(cnt) == 16'hffff && cnt != 16'hffff && !$past(wr) &&
    $past(i_reload_mode) == 2'h1 |-> cnt == $past(o_reload_capture_value))
    else $error("overflow did not reload");
  match_value_a:
  assert property (o_match_pulse[1] |-> $past(cnt) == $past(o_compare_capture_one) &&
    $past(i_chan_func[3:2]) == 2'h1 ##1 !o_match_pulse[1]) else $error("bad match pulse");
  mode0_set_a:
  assert property (o_match_pulse[1] && !$past(i_compare_mode_one) |-> o_compare_out[1])
    else $error("match did not set output");
  mode0_rise_a:
  assert property ($rose(o_compare_out[1]) && !$past(i_compare_mode_one) &&
    $past(i_chan_func[3:2]) == 2'h1 |-> o_match_pulse[1]) else $error("output rose without match");
  cap_write_a:
  assert property ($past(i_reg_low_wr[3], 2) && $past(i_chan_func[7:6], 2) == 2'h3
    |-> o_compare_capture_three == $past(cnt)) else $error("write capture wrong");
  cap_pin_a:
  assert property (o_capture_pulse[2] |-> $past(i_chan_func[5:4]) == 2'h2 &&
    o_compare_capture_two == $past(cnt)) else $error("pin capture wrong");
  ext_flag_en_a:
  assert property ($rose(o_external_reload_flag) |-> $past(i_external_reload_enable))
    else $error("reload flag set while disabled");
endmodule
bind tcc_timer2 tcc_timer2_monitor tcc_timer2_monitor_i (.*);
